// >>> rtl/sfb_bank0.sv
// Bank 0 special register file with an AXI4-Lite slave port, port latches and pin readback.
// Assumes peripherals drive sfb_events_t on aclk; pins and reset-cause lines are asynchronous.
//
// Contract
// RULE_01: Special registers are plain storage, read and written by core and peripherals.
// RULE_02: Index 00h accesses data memory at the pointer; not a real register.
// RULE_03: Timer0 count at 01h: cleared on power reset, kept by other resets.
// RULE_04: Program counter low byte at 02h clears on every reset.
// RULE_05: Core flags at 03h: bank selects, time-out, power-down, zero, digit carry, carry.
// RULE_06: Indirect pointer at 04h, cleared on power reset, kept otherwise.
// RULE_07: Port A six bits: writes set latch, reads return pins.
// RULE_08: Ports B, C, D: writes set latch, reads return pins, kept on non-power reset.
// RULE_09: Port E has only bits 2 to 0.
// RULE_10: Upper counter write buffer at 0Ah, five bits, clears on every reset.
// RULE_11: Interrupt control at 0Bh: five enables then three flags, flag bit0 kept.
// RULE_12: Peripheral flags 1 at 0Ch, bit 3 unimplemented, clears on reset.
// RULE_13: Peripheral flags 2 at 0Dh holds only the write-complete flag in bit 4.
// RULE_14: Timer1 count bytes at 0Eh and 0Fh kept by non-power resets.
// RULE_15: Timer1 control at 10h uses bits 5 to 0, kept by non-power resets.
// RULE_16: Timer2 count at 11h clears on every reset.
// RULE_17: Timer2 control at 12h: postscale, on bit, prescale; bit 7 unimplemented.
// RULE_18: Capture bytes at 15h, 16h kept; capture control at 17h clears always.
// RULE_19: Serial receive status at 18h: five controls, two errors, ninth received bit.
// RULE_20: Serial transmit and receive buffers at 19h and 1Ah clear on every reset.
// RULE_21: Converter result at 1Eh kept; converter control at 1Fh, bit 1 unimplemented.
// RULE_22: Unimplemented bits and gaps read as zero; unknown bits load zero here.
// RULE_23: Non-power reset values apply to external and watchdog resets.
// RULE_24: A program counter low write loads counter bits 12 to 8 from the buffer.
// RULE_25: Indices 00h to 1Fh decode; gaps read zero, beyond answers an error.
`timescale 1ns/1ps
`default_nettype none

module sfb_bank0 (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [sfb_pkg::SFB_ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [sfb_pkg::SFB_ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic power_on_cause,
   input wire logic watchdog_cause,
   input wire sfb_pkg::sfb_pins_t pins_in,
   input wire sfb_pkg::sfb_events_t events,
   output sfb_pkg::sfb_pins_t pins_out,
   output sfb_pkg::sfb_ctrl_t ctrl,
   output logic [12:0] program_counter,
   output logic transmit_load
);

   logic [7:0] regs_reg [0:31];
   logic [7:0] hw_set [0:31];
   logic [7:0] hw_ld_mask [0:31];
   logic [7:0] hw_ld_val [0:31];
   logic [7:0] data_mem [0:255];
   sfb_pkg::sfb_pins_t pins_meta_reg;
   sfb_pkg::sfb_pins_t pins_sync_reg;
   logic [1:0] cause_meta_reg;
   logic [1:0] cause_sync_reg;
   logic aw_held_reg;
   logic w_held_reg;
   logic [sfb_pkg::SFB_ADDR_W-1:0] awaddr_reg;
   logic [7:0] wdata_reg;
   logic wlane_reg;
   logic [12:0] pc_reg;
   logic tx_load_reg;
   logic [7:0] rd_byte;
   logic rd_hit;
   logic wr_fire;
   logic wr_hit;
   logic [4:0] wr_idx;
   logic [4:0] rd_idx;

   // Pins and reset-cause lines are asynchronous; only the second stage is used.
   always_ff @(posedge aclk) begin
      pins_meta_reg <= pins_in;
      pins_sync_reg <= pins_meta_reg;
      cause_meta_reg <= {power_on_cause, watchdog_cause};
      cause_sync_reg <= cause_meta_reg;
   end

   // Write address and data are taken independently and held until both are present.
   assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
   assign wr_idx = awaddr_reg[6:2];
   assign wr_hit = (awaddr_reg[7] == 1'b0); // RULE_25

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         awaddr_reg <= '0;
         wdata_reg <= sfb_pkg::SFB_ZERO;
         wlane_reg <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= sfb_pkg::SFB_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr;
         end else if (wr_fire) begin
            aw_held_reg <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            wdata_reg <= s_axi_wdata[7:0];
            wlane_reg <= s_axi_wstrb[0];
         end else if (wr_fire) begin
            w_held_reg <= 1'b0;
         end
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? sfb_pkg::SFB_RESP_OKAY : sfb_pkg::SFB_RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_awready <= !aw_held_reg && !(s_axi_awvalid && s_axi_awready);
         s_axi_wready <= !w_held_reg && !(s_axi_wvalid && s_axi_wready);
      end
   end

   // Peripheral events; a set arriving with a software clear wins.
   always_comb begin
      for (int k = 0; k < sfb_pkg::SFB_NREG; k++) begin
         hw_set[k] = sfb_pkg::SFB_ZERO;
         hw_ld_mask[k] = sfb_pkg::SFB_ZERO;
         hw_ld_val[k] = sfb_pkg::SFB_ZERO;
      end
      hw_set[sfb_pkg::SFB_IDX_INTERRUPT_CONTROL] = {5'h00, events.interrupt_control_set}; // RULE_11
      hw_set[sfb_pkg::SFB_IDX_PERIPHERAL_FLAGS_1] =
         events.periph1_set & sfb_pkg::SFB_PERIPH1_FLAG_MASK; // RULE_12
      hw_set[sfb_pkg::SFB_IDX_PERIPHERAL_FLAGS_2][sfb_pkg::SFB_BIT_EEPROM_DONE] =
         events.eeprom_done_set; // RULE_13
      hw_set[sfb_pkg::SFB_IDX_SERIAL_RECEIVE_STATUS][sfb_pkg::SFB_BIT_FRAMING_ERROR] =
         events.framing_error_set; // RULE_19
      hw_set[sfb_pkg::SFB_IDX_SERIAL_RECEIVE_STATUS][sfb_pkg::SFB_BIT_OVERRUN_ERROR] =
         events.overrun_error_set;
      if (events.rx_load) begin
         hw_ld_mask[sfb_pkg::SFB_IDX_SERIAL_RECEIVE_STATUS][sfb_pkg::SFB_BIT_RX_NINTH] = 1'b1;
         hw_ld_val[sfb_pkg::SFB_IDX_SERIAL_RECEIVE_STATUS][sfb_pkg::SFB_BIT_RX_NINTH] =
            events.rx_ninth;
         hw_ld_mask[sfb_pkg::SFB_IDX_SERIAL_RECEIVE_BUFFER] = sfb_pkg::SFB_ONES; // RULE_20
         hw_ld_val[sfb_pkg::SFB_IDX_SERIAL_RECEIVE_BUFFER] = events.rx_data;
      end
      if (events.conv_load) begin
         hw_ld_mask[sfb_pkg::SFB_IDX_CONVERSION_RESULT_HIGH] = sfb_pkg::SFB_ONES; // RULE_21
         hw_ld_val[sfb_pkg::SFB_IDX_CONVERSION_RESULT_HIGH] = events.conv_result;
         hw_ld_mask[sfb_pkg::SFB_IDX_CONVERSION_CONTROL][sfb_pkg::SFB_BIT_GO_DONE] = 1'b1;
      end
   end

   // One storage byte per index; masks and keep bits come from the package tables.
   for (genvar i = 0; i < sfb_pkg::SFB_NREG; i++) begin : g_reg
      logic [7:0] wr_val;
      assign wr_val = (wr_fire && wr_hit && wlane_reg && wr_idx == 5'(i)) ?
         ((regs_reg[i] & ~sfb_pkg::SFB_WMASK[i]) | (wdata_reg & sfb_pkg::SFB_WMASK[i])) :
         regs_reg[i]; // RULE_01
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            if (cause_sync_reg[1]) begin
               // Bits of unknown power-up value are given zero for repeatability.
               regs_reg[i] <= (5'(i) == sfb_pkg::SFB_IDX_CORE_FLAGS) ?
                  sfb_pkg::SFB_CORE_FLAGS_POR : sfb_pkg::SFB_ZERO; // RULE_03 RULE_05 RULE_22
            end else if (5'(i) == sfb_pkg::SFB_IDX_CORE_FLAGS) begin
               regs_reg[i] <= regs_reg[i] & sfb_pkg::SFB_KEEP[i]; // RULE_05 RULE_23
               regs_reg[i][sfb_pkg::SFB_BIT_TIME_OUT] <= !cause_sync_reg[0];
            end else begin
               regs_reg[i] <= regs_reg[i] & sfb_pkg::SFB_KEEP[i]; // RULE_23 RULE_06 RULE_14
            end
         end else begin
            regs_reg[i] <= ((wr_val & ~hw_ld_mask[i]) | (hw_ld_val[i] & hw_ld_mask[i]))
               | hw_set[i];
         end
      end
   end

   // The indirect window reaches a separate byte store; it is not reset by design.
   always_ff @(posedge aclk) begin
      if (aresetn && wr_fire && wr_hit && wlane_reg &&
          wr_idx == sfb_pkg::SFB_IDX_INDIRECT_DATA_WINDOW) begin
         data_mem[regs_reg[sfb_pkg::SFB_IDX_INDIRECT_POINTER]] <= wdata_reg; // RULE_02
      end
   end

   // Writing the low counter byte loads the upper bits from the write buffer.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pc_reg <= '0; // RULE_04
         tx_load_reg <= 1'b0;
      end else begin
         tx_load_reg <= wr_fire && wr_hit && wlane_reg &&
            wr_idx == sfb_pkg::SFB_IDX_SERIAL_TRANSMIT_BUFFER;
         if (wr_fire && wr_hit && wlane_reg &&
             wr_idx == sfb_pkg::SFB_IDX_PROGRAM_COUNTER_LOW) begin
            pc_reg <= {regs_reg[sfb_pkg::SFB_IDX_PC_UPPER_LATCH][4:0], wdata_reg}; // RULE_24 RULE_10
         end
      end
   end

   // Read decode; ports return the synchronised pin levels, not the latches.
   assign rd_idx = s_axi_araddr[6:2];
   assign rd_hit = (s_axi_araddr[7] == 1'b0); // RULE_25
   always_comb begin
      if (!rd_hit) begin
         rd_byte = sfb_pkg::SFB_ZERO;
      end else if (rd_idx == sfb_pkg::SFB_IDX_INDIRECT_DATA_WINDOW) begin
         // A zero pointer addresses the window itself, which reads zero.
         rd_byte = (regs_reg[sfb_pkg::SFB_IDX_INDIRECT_POINTER] == sfb_pkg::SFB_ZERO) ?
            sfb_pkg::SFB_ZERO : data_mem[regs_reg[sfb_pkg::SFB_IDX_INDIRECT_POINTER]]; // RULE_02
      end else if (rd_idx == sfb_pkg::SFB_IDX_PORT_A_DATA) begin
         rd_byte = {2'h0, pins_sync_reg.port_a}; // RULE_07
      end else if (rd_idx == sfb_pkg::SFB_IDX_PORT_B_DATA) begin
         rd_byte = pins_sync_reg.port_b; // RULE_08
      end else if (rd_idx == sfb_pkg::SFB_IDX_PORT_C_DATA) begin
         rd_byte = pins_sync_reg.port_c;
      end else if (rd_idx == sfb_pkg::SFB_IDX_PORT_D_DATA) begin
         rd_byte = pins_sync_reg.port_d;
      end else if (rd_idx == sfb_pkg::SFB_IDX_PORT_E_DATA) begin
         rd_byte = {5'h00, pins_sync_reg.port_e}; // RULE_09
      end else if (rd_idx == sfb_pkg::SFB_IDX_SERIAL_TRANSMIT_BUFFER) begin
         rd_byte = sfb_pkg::SFB_ZERO;
      end else begin
         rd_byte = regs_reg[rd_idx]; // RULE_22
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= sfb_pkg::SFB_RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_byte};
            s_axi_rresp <= rd_hit ? sfb_pkg::SFB_RESP_OKAY : sfb_pkg::SFB_RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   assign pins_out.port_a = regs_reg[sfb_pkg::SFB_IDX_PORT_A_DATA][5:0]; // RULE_07
   assign pins_out.port_b = regs_reg[sfb_pkg::SFB_IDX_PORT_B_DATA]; // RULE_08
   assign pins_out.port_c = regs_reg[sfb_pkg::SFB_IDX_PORT_C_DATA];
   assign pins_out.port_d = regs_reg[sfb_pkg::SFB_IDX_PORT_D_DATA];
   assign pins_out.port_e = regs_reg[sfb_pkg::SFB_IDX_PORT_E_DATA][2:0]; // RULE_09
   assign ctrl.timer0_count = regs_reg[sfb_pkg::SFB_IDX_TIMER0_COUNT];
   assign ctrl.core_flags = regs_reg[sfb_pkg::SFB_IDX_CORE_FLAGS];
   assign ctrl.indirect_pointer = regs_reg[sfb_pkg::SFB_IDX_INDIRECT_POINTER];
   assign ctrl.interrupt_control = regs_reg[sfb_pkg::SFB_IDX_INTERRUPT_CONTROL];
   assign ctrl.peripheral_flags_1 = regs_reg[sfb_pkg::SFB_IDX_PERIPHERAL_FLAGS_1];
   assign ctrl.peripheral_flags_2 = regs_reg[sfb_pkg::SFB_IDX_PERIPHERAL_FLAGS_2];
   assign ctrl.timer1_count = {regs_reg[sfb_pkg::SFB_IDX_TIMER1_COUNT_HIGH],
      regs_reg[sfb_pkg::SFB_IDX_TIMER1_COUNT_LOW]}; // RULE_14
   assign ctrl.timer1_control = regs_reg[sfb_pkg::SFB_IDX_TIMER1_CONTROL]; // RULE_15
   assign ctrl.timer2_count = regs_reg[sfb_pkg::SFB_IDX_TIMER2_COUNT]; // RULE_16
   assign ctrl.timer2_control = regs_reg[sfb_pkg::SFB_IDX_TIMER2_CONTROL]; // RULE_17
   assign ctrl.capture_compare = {regs_reg[sfb_pkg::SFB_IDX_CAPTURE_COMPARE_HIGH],
      regs_reg[sfb_pkg::SFB_IDX_CAPTURE_COMPARE_LOW]}; // RULE_18
   assign ctrl.capture_compare_control = regs_reg[sfb_pkg::SFB_IDX_CAPTURE_COMPARE_CONTROL];
   assign ctrl.serial_receive_status = regs_reg[sfb_pkg::SFB_IDX_SERIAL_RECEIVE_STATUS];
   assign ctrl.serial_transmit_buffer = regs_reg[sfb_pkg::SFB_IDX_SERIAL_TRANSMIT_BUFFER];
   assign ctrl.conversion_control = regs_reg[sfb_pkg::SFB_IDX_CONVERSION_CONTROL]; // RULE_21
   assign program_counter = pc_reg;
   assign transmit_load = tx_load_reg;

endmodule // sfb_bank0

`default_nettype wire

// >>> rtl/sfb_pkg.sv
// Package for the bank 0 special register file: offsets, field layout, masks and carriers.
// Assumes a single 20 MHz clock domain and a 32-bit AXI4-Lite register bus.
package sfb_pkg;

   localparam int SFB_ADDR_W = 8;
   localparam int SFB_NREG = 32;

   // Register indices; the bus byte address is four times the index.
   localparam logic [4:0] SFB_IDX_INDIRECT_DATA_WINDOW = 5'h00;
   localparam logic [4:0] SFB_IDX_TIMER0_COUNT = 5'h01;
   localparam logic [4:0] SFB_IDX_PROGRAM_COUNTER_LOW = 5'h02;
   localparam logic [4:0] SFB_IDX_CORE_FLAGS = 5'h03;
   localparam logic [4:0] SFB_IDX_INDIRECT_POINTER = 5'h04;
   localparam logic [4:0] SFB_IDX_PORT_A_DATA = 5'h05;
   localparam logic [4:0] SFB_IDX_PORT_B_DATA = 5'h06;
   localparam logic [4:0] SFB_IDX_PORT_C_DATA = 5'h07;
   localparam logic [4:0] SFB_IDX_PORT_D_DATA = 5'h08;
   localparam logic [4:0] SFB_IDX_PORT_E_DATA = 5'h09;
   localparam logic [4:0] SFB_IDX_PC_UPPER_LATCH = 5'h0a;
   localparam logic [4:0] SFB_IDX_INTERRUPT_CONTROL = 5'h0b;
   localparam logic [4:0] SFB_IDX_PERIPHERAL_FLAGS_1 = 5'h0c;
   localparam logic [4:0] SFB_IDX_PERIPHERAL_FLAGS_2 = 5'h0d;
   localparam logic [4:0] SFB_IDX_TIMER1_COUNT_LOW = 5'h0e;
   localparam logic [4:0] SFB_IDX_TIMER1_COUNT_HIGH = 5'h0f;
   localparam logic [4:0] SFB_IDX_TIMER1_CONTROL = 5'h10;
   localparam logic [4:0] SFB_IDX_TIMER2_COUNT = 5'h11;
   localparam logic [4:0] SFB_IDX_TIMER2_CONTROL = 5'h12;
   localparam logic [4:0] SFB_IDX_CAPTURE_COMPARE_LOW = 5'h15;
   localparam logic [4:0] SFB_IDX_CAPTURE_COMPARE_HIGH = 5'h16;
   localparam logic [4:0] SFB_IDX_CAPTURE_COMPARE_CONTROL = 5'h17;
   localparam logic [4:0] SFB_IDX_SERIAL_RECEIVE_STATUS = 5'h18;
   localparam logic [4:0] SFB_IDX_SERIAL_TRANSMIT_BUFFER = 5'h19;
   localparam logic [4:0] SFB_IDX_SERIAL_RECEIVE_BUFFER = 5'h1a;
   localparam logic [4:0] SFB_IDX_CONVERSION_RESULT_HIGH = 5'h1e;
   localparam logic [4:0] SFB_IDX_CONVERSION_CONTROL = 5'h1f;

   // Field positions.
   localparam int SFB_BIT_TIME_OUT = 4;
   localparam int SFB_BIT_GO_DONE = 2;
   localparam int SFB_BIT_EEPROM_DONE = 4;
   localparam int SFB_BIT_FRAMING_ERROR = 2;
   localparam int SFB_BIT_OVERRUN_ERROR = 1;
   localparam int SFB_BIT_RX_NINTH = 0;

   // Reset values and masks.
   localparam logic [7:0] SFB_CORE_FLAGS_POR = 8'h18;
   localparam logic [7:0] SFB_PERIPH1_FLAG_MASK = 8'hf7;
   localparam logic [7:0] SFB_ZERO = 8'h00;
   localparam logic [7:0] SFB_ONES = 8'hff;
   localparam logic [1:0] SFB_RESP_OKAY = 2'h0;
   localparam logic [1:0] SFB_RESP_SLVERR = 2'h2;

   // Bits software may write, per index; zero bits read back as stored or zero.
   localparam logic [7:0] SFB_WMASK [0:31] = '{
      8'h00, 8'hff, 8'hff, 8'he7, 8'hff, 8'h3f, 8'hff, 8'hff,
      8'hff, 8'h07, 8'h1f, 8'hff, 8'hf7, 8'h10, 8'hff, 8'hff,
      8'h3f, 8'hff, 8'h7f, 8'h00, 8'h00, 8'hff, 8'hff, 8'h3f,
      8'hf8, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hfd};

   // Bits kept through a non-power reset, per index; all other bits clear, save the core flags time-out bit.
   localparam logic [7:0] SFB_KEEP [0:31] = '{
      8'h00, 8'hff, 8'h00, 8'h0f, 8'hff, 8'h10, 8'hff, 8'hff,
      8'hff, 8'h07, 8'h00, 8'h01, 8'h00, 8'h00, 8'hff, 8'hff,
      8'h3f, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00,
      8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00};

   typedef struct packed {
      logic [5:0] port_a;
      logic [7:0] port_b;
      logic [7:0] port_c;
      logic [7:0] port_d;
      logic [2:0] port_e;
   } sfb_pins_t;

   typedef struct packed {
      logic [2:0] interrupt_control_set;
      logic [7:0] periph1_set;
      logic eeprom_done_set;
      logic framing_error_set;
      logic overrun_error_set;
      logic rx_load;
      logic rx_ninth;
      logic [7:0] rx_data;
      logic conv_load;
      logic [7:0] conv_result;
   } sfb_events_t;

   typedef struct packed {
      logic [7:0] timer0_count;
      logic [7:0] core_flags;
      logic [7:0] indirect_pointer;
      logic [7:0] interrupt_control;
      logic [7:0] peripheral_flags_1;
      logic [7:0] peripheral_flags_2;
      logic [15:0] timer1_count;
      logic [7:0] timer1_control;
      logic [7:0] timer2_count;
      logic [7:0] timer2_control;
      logic [15:0] capture_compare;
      logic [7:0] capture_compare_control;
      logic [7:0] serial_receive_status;
      logic [7:0] serial_transmit_buffer;
      logic [7:0] conversion_control;
   } sfb_ctrl_t;

endpackage

// >>> bench/sfb_bank0_sva.sv
// Checker for the bank 0 register file, bound to the top module ports.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module sfb_bank0_chk (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [sfb_pkg::SFB_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic power_on_cause,
   input wire sfb_pkg::sfb_events_t events,
   input wire sfb_pkg::sfb_ctrl_t ctrl,
   input wire logic [12:0] program_counter,
   input wire logic transmit_load
);
   default clocking cb @(posedge aclk);
   endclocking
   a_rdata_upper_zero: assert property (disable iff (!aresetn) s_axi_rvalid |->
      s_axi_rdata[31:8] == 24'h0) else $error("read data upper bits not zero");
   a_read_one_cycle: assert property (disable iff (!aresetn)
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
   a_read_holds: assert property (disable iff (!aresetn) s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
   a_write_holds: assert property (disable iff (!aresetn) s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
   a_bad_read_err: assert property (disable iff (!aresetn)
      s_axi_arvalid && s_axi_arready && s_axi_araddr[7] |=> s_axi_rresp == 2'h2
      && s_axi_rdata == 32'h0) else $error("out of range read not refused");
   // Reset checks carry no disable, since they look at what reset itself does.
   a_reset_clears: assert property (!aresetn |=> program_counter == 13'h0
      && ctrl.timer2_count == 8'h0 && ctrl.serial_transmit_buffer == 8'h0
      && ctrl.capture_compare_control == 8'h0) else $error("reset did not clear");
   a_power_core_flags: assert property (!aresetn && power_on_cause
      && $past(power_on_cause, 2) |=> ctrl.core_flags == 8'h18) else $error("core flags wrong");
   a_warm_keeps: assert property (!aresetn && !power_on_cause && $past(!power_on_cause, 2)
      |=> ctrl.timer1_count == $past(ctrl.timer1_count) && ctrl.timer0_count ==
      $past(ctrl.timer0_count) && ctrl.indirect_pointer == $past(ctrl.indirect_pointer))
      else $error("warm reset lost a kept register");
   a_unimpl_zero: assert property (disable iff (!aresetn) ctrl.peripheral_flags_1[3] == 1'b0
      && ctrl.timer2_control[7] == 1'b0 && ctrl.conversion_control[1] == 1'b0
      && (ctrl.peripheral_flags_2 & 8'hef) == 8'h0) else $error("unimplemented bit set");
   a_conv_clears_go: assert property (disable iff (!aresetn) events.conv_load
      |=> !ctrl.conversion_control[2]) else $error("go bit not cleared");
   a_tx_pulse_once: assert property (disable iff (!aresetn) transmit_load
      |=> !transmit_load) else $error("transmit load longer than a cycle");
   c_write: cover property (s_axi_bvalid && s_axi_bready);
   c_bad_read: cover property (s_axi_arvalid && s_axi_arready && s_axi_araddr[7]);
   c_conv: cover property (events.conv_load);
endmodule // sfb_bank0_chk
bind sfb_bank0 sfb_bank0_chk u_chk (.aclk(aclk), .aresetn(aresetn),
   .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .power_on_cause(power_on_cause), .events(events),
   .ctrl(ctrl), .program_counter(program_counter), .transmit_load(transmit_load));
`default_nettype wire

// >>> bench/tb_bank0_special_register_file.sv
// Bench for the bank 0 register file: bus tasks and one task per scenario.
// Assumes the design answers the bus itself; pins and events are driven here.
`timescale 1ns/1ps
`default_nettype none
module tb_bank0_special_register_file;
   logic aclk, aresetn, por, wdt, tx_load;
   logic [7:0] awaddr, araddr;
   logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
   logic [31:0] wdata, rdata;
   logic [1:0] bresp, rresp;
   sfb_pkg::sfb_pins_t pins_in, pins_out;
   sfb_pkg::sfb_events_t events;
   sfb_pkg::sfb_ctrl_t ctrl;
   logic [12:0] pc;
   int failures, comparisons, tx_count;
   localparam logic [7:0] AFTER_FF [0:31] = '{8'h00, 8'hff, 8'hff, 8'hff, 8'hff, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h1f, 8'hff, 8'hf7, 8'h10, 8'hff, 8'hff, 8'h3f, 8'hff,
      8'h7f, 8'h00, 8'h00, 8'hff, 8'hff, 8'h3f, 8'hf8, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'hfd};
   localparam logic [7:0] AFTER_WARM [0:31] = '{1: 8'hff, 3: 8'h1f, 4: 8'hff, 11: 8'h01,
      14: 8'hff, 15: 8'hff, 16: 8'h3f, 21: 8'hff, 22: 8'hff, default: 8'h00};

   sfb_bank0 dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .power_on_cause(por), .watchdog_cause(wdt), .pins_in(pins_in), .events(events),
      .pins_out(pins_out), .ctrl(ctrl), .program_counter(pc), .transmit_load(tx_load));

   initial begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end

   always @(posedge aclk) if (tx_load === 1'b1) tx_count++;

   task automatic end_of_test();
      if (failures == 0 && comparisons > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Each bus task opens with an edge so a valid never drops and rises in one step.
   task automatic wr(input logic [5:0] idx, input logic [7:0] d, output logic [1:0] r);
      int n;
      @(posedge aclk);
      awaddr <= {idx, 2'b00};
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid && n < 50);
      r = bresp;
      bready <= 1'b0;
      if (n >= 50) begin
         failures++;
         end_of_test();
      end
   endtask

   task automatic rd(input logic [5:0] idx, output logic [31:0] d, output logic [1:0] r);
      int n;
      @(posedge aclk);
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
         if (arready) arvalid <= 1'b0;
      end while (!rvalid && n < 50);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      if (n >= 50) begin
         failures++;
         end_of_test();
      end
   endtask

   task automatic rd_chk(input logic [5:0] idx, input logic [7:0] e);
      logic [31:0] d;
      logic [1:0] r;
      rd(idx, d, r);
      chk(d, {24'h0, e});
      chk(r, 2'h0);
   endtask

   task automatic wr_ok(input logic [5:0] idx, input logic [7:0] d);
      logic [1:0] r;
      wr(idx, d, r);
      chk(r, 2'h0);
   endtask

   task automatic do_reset(input logic p, input logic w);
      @(posedge aclk);
      por <= p;
      wdt <= w;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
   endtask

   // Mode 0 follows a power reset, 1 a write of all ones, 2 an external reset after that.
   task automatic check_all(input int mode);
      logic [7:0] e;
      for (int i = 0; i < 32; i++) begin
         e = (mode == 0) ? ((i == 3) ? 8'h18 : 8'h00) : (mode == 1) ? AFTER_FF[i] : AFTER_WARM[i];
         if ((i < 5 || i > 9) && !(mode != 0 && i == 0)) rd_chk(i[5:0], e);
      end
   endtask

   task automatic t_write_all();
      for (int i = 1; i < 32; i++) if (i < 5 || i > 9) wr_ok(i[5:0], 8'hff);
      check_all(1);
   endtask

   task automatic t_warm_reset();
      do_reset(1'b0, 1'b0);
      check_all(2);
      do_reset(1'b0, 1'b1);
      rd_chk(6'h03, 8'h0f);
   endtask

   task automatic t_events();
      wr_ok(6'h1f, 8'h05);
      @(posedge aclk);
      events <= '{3'h6, 8'hff, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 8'h3c, 1'b1, 8'h96};
      @(posedge aclk);
      events <= '0;
      rd_chk(6'h0b, 8'h07);
      rd_chk(6'h0c, 8'hf7);
      rd_chk(6'h0d, 8'h10);
      rd_chk(6'h18, 8'h07);
      rd_chk(6'h1a, 8'h3c);
      rd_chk(6'h1e, 8'h96);
      rd_chk(6'h1f, 8'h01);
   endtask

   task automatic t_pc_indirect();
      wr_ok(6'h0a, 8'h15);
      wr_ok(6'h02, 8'h3c);
      chk(pc, 13'h153c);
      wr_ok(6'h0a, 8'h0a);
      chk(pc, 13'h153c);
      wr_ok(6'h04, 8'h40);
      wr_ok(6'h00, 8'ha5);
      wr_ok(6'h04, 8'h41);
      wr_ok(6'h00, 8'h5a);
      wr_ok(6'h04, 8'h40);
      rd_chk(6'h00, 8'ha5);
      wr_ok(6'h04, 8'h41);
      rd_chk(6'h00, 8'h5a);
   endtask

   task automatic t_ports_misc();
      logic [31:0] d;
      logic [1:0] r;
      int n0;
      @(posedge aclk);
      pins_in <= {6'h2a, 8'h5a, 8'hc3, 8'h96, 3'h5};
      wr_ok(6'h05, 8'h15);
      wr_ok(6'h06, 8'ha5);
      wr_ok(6'h07, 8'h3c);
      wr_ok(6'h08, 8'h69);
      wr_ok(6'h09, 8'hfa);
      chk(pins_out, {6'h15, 8'ha5, 8'h3c, 8'h69, 3'h2});
      rd_chk(6'h05, 8'h2a);
      rd_chk(6'h06, 8'h5a);
      rd_chk(6'h08, 8'h96);
      rd_chk(6'h09, 8'h05);
      n0 = tx_count;
      wr_ok(6'h19, 8'h5a);
      repeat (2) @(posedge aclk);
      chk(tx_count, n0 + 1);
      chk(ctrl.serial_transmit_buffer, 8'h5a);
      wr(6'h20, 8'hff, r);
      chk(r, 2'h2);
      rd(6'h3f, d, r);
      chk({r, d}, 34'h200000000);
      rd_chk(6'h00, 8'h5a);
   endtask

   initial begin
      {aresetn, wdt, awvalid, wvalid, bready, arvalid, rready} = '0;
      por = 1'b1;
      {awaddr, araddr, wdata, pins_in, events} = '0;
      {failures, comparisons, tx_count} = '0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      check_all(0);
      t_write_all();
      t_warm_reset();
      t_events();
      t_pc_indirect();
      t_ports_misc();
      end_of_test();
   end
endmodule // tb_bank0_special_register_file
`default_nettype wire
